// ---- hw/wer_regs.vh ----
// Constants for the wake-up event routing block.
// Assumes byte-wide registers, one per aligned 32-bit Wishbone word.
// Notes on behaviour
// - Config and routing registers reset to zero
// - Config bits 1-0 select banked register space
// - Routing enables live in bank 2 only
// - Config bit 2 swaps keyboard and mouse inputs
// - Management route lo: per-source enables, 5,7 reserved
// - Management interrupt ignores main wake enables
// - Management route hi: bit n per event input
// - Interrupt route lo mirrors management route layout
// - Enabled events drive assigned interrupt channel
// - Interrupt channel ignores main wake enables
// - Wake request for events with main enable
// - Sticky status per event; shared-pin function select
`ifndef WER_REGS_VH
`define WER_REGS_VH
// Offsets are register indices; byte address is four times
`define WER_IDX_STAT_LO     5'h00
`define WER_IDX_STAT_HI     5'h01
`define WER_IDX_EN_LO       5'h02
`define WER_IDX_EN_HI       5'h03
`define WER_IDX_CFG         5'h04
`define WER_IDX_MGT_LO      5'h13
`define WER_IDX_MGT_HI      5'h14
`define WER_IDX_IRQ_LO      5'h15
`define WER_IDX_IRQ_HI      5'h16
`define WER_IDX_CTRL        5'h08
`define WER_IDX_HSTAT       5'h09
`define WER_IDX_HMASK       5'h0a
`define WER_BANK_ROUTE      2'h2
`define WER_CFG_BANK_LSB    0
`define WER_CFG_SWAP_BIT    2
`define WER_CFG_PB_BIT      3
`define WER_CFG_MASK        8'h0f
`define WER_LO_MASK         8'h5f
`define WER_CTRL_SWEV_BIT   0
`define WER_CTRL_SEL_BIT    1
`define WER_RST_BYTE        8'h00
`endif

// ---- hw/wer_sync.v ----
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous active-low reset; output settles after change.
`timescale 1ns/1ps
module wer_sync
(
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] d_i,
    output reg  [7:0] q_o
);
    reg [7:0] s1_r;
    reg [7:0] s2_r;
    reg [7:0] s3_r;
    genvar    g;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change counts only when stages two and three agree
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : agree
            always @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    q_o[g] <= 1'b0;
                else if (s2_r[g] == s3_r[g])
                    q_o[g] <= s3_r[g];
            end
        end
    endgenerate
endmodule

// ---- hw/wer_sticky.v ----
// Sticky event status byte with rising-edge detect.
// Assumes event levels already synchronised; set wins over clear.
`timescale 1ns/1ps
module wer_sticky
(
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] lvl_i,
    input  wire [7:0] clr_i,
    output reg  [7:0] stat_o
);
    reg [7:0] prev_r;
    wire [7:0] rise;

    assign rise = lvl_i & ~prev_r;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_r <= 8'h00;
            stat_o <= 8'h00;
        end
        else
        begin
            prev_r <= lvl_i;
            stat_o <= (stat_o & ~clr_i) | rise;
        end
    end
endmodule

// ---- hw/wer_top.v ----
// Wake-up event routing: config, routing enables, outputs.
// Assumes classic Wishbone master, 40 MHz clock, pin-level events.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "wer_regs.vh"
module wer_top
(
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [6:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    input  wire        ring_indicator_one_i,
    input  wire        ring_indicator_two_i,
    input  wire        keyboard_event_i,
    input  wire        mouse_event_i,
    input  wire        consumer_infrared_i,
    input  wire [7:0]  general_event_input_i,
    input  wire        ring_event_i,
    input  wire        keyboard_clock_in_i,
    input  wire        keyboard_data_in_i,
    input  wire        mouse_clock_in_i,
    input  wire        mouse_data_in_i,
    output reg         ctlr_kbd_clock_o,
    output reg         ctlr_kbd_data_o,
    output reg         ctlr_mouse_clock_o,
    output reg         ctlr_mouse_data_o,
    output reg         system_mgmt_interrupt_n_o,
    output reg         wakeup_irq_o,
    output reg         power_wake_request_n_o,
    output reg         pb_pulse_s3_en_o,
    output reg         host_irq_o
);
    reg  [7:0] cfg_r;
    reg  [7:0] mgt_lo_r;
    reg  [7:0] mgt_hi_r;
    reg  [7:0] irq_lo_r;
    reg  [7:0] irq_hi_r;
    reg  [7:0] en_lo_r;
    reg  [7:0] en_hi_r;
    reg  [1:0] ctrl_r;
    reg  [7:0] hmask_r;
    reg  [7:0] hstat_r;
    reg  [7:0] rd_nxt;
    reg        hit_nxt;
    reg        prev_mgt_r;
    reg        prev_irq_r;
    reg        prev_pwr_r;
    wire [7:0] raw_lo;
    wire [7:0] raw_hi;
    wire [7:0] sync_lo;
    wire [7:0] sync_hi;
    wire [7:0] lvl_lo;
    wire [7:0] kbd_sync;
    wire [7:0] stat_lo;
    wire [7:0] stat_hi;
    wire [7:0] clr_lo;
    wire [7:0] clr_hi;
    wire [7:0] hevt;
    wire       req;
    wire       wr;
    wire       rd;
    wire       mgt_any;
    wire       irq_any;
    wire       pwr_any;
    wire [4:0] idx;

    // Read decode used for every banked register
    function in_bank2;
        input [1:0] bank;
        begin
            in_bank2 = (bank == `WER_BANK_ROUTE);
        end
    endfunction

    // Routed level: any sticky status bit whose enable is set
    function route_any;
        input [7:0] st_lo;
        input [7:0] st_hi;
        input [7:0] en_lo;
        input [7:0] en_hi;
        begin
            route_any = |(st_lo & en_lo) | |(st_hi & en_hi);
        end
    endfunction

    // Clear strobe for one byte of read-to-clear status
    function [7:0] rd_clear;
        input       rd_en;
        input [4:0] at;
        input [4:0] target;
        begin
            rd_clear = (rd_en && at == target) ? 8'hff : 8'h00;
        end
    endfunction

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr  = req & wb_we_i & wb_sel_i[0] & hit_nxt;
    assign rd  = req & ~wb_we_i & hit_nxt;
    assign idx = wb_adr_i[6:2];

    // Shared pin: ring event replaces input four when selected
    assign raw_lo = {3'h0, consumer_infrared_i, mouse_event_i,
                     keyboard_event_i, ring_indicator_two_i,
                     ring_indicator_one_i};
    assign raw_hi = {general_event_input_i[7:5],
                     ctrl_r[`WER_CTRL_SEL_BIT] ? ring_event_i
                                               : general_event_input_i[4],
                     general_event_input_i[3:0]};

    // Two-stage agreement: pulses under two clocks are dropped
    wer_sync u_sync_lo
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (raw_lo),
        .q_o     (sync_lo)
    );

    wer_sync u_sync_hi
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (raw_hi),
        .q_o     (sync_hi)
    );

    wer_sync u_sync_kbd
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({4'h0, keyboard_clock_in_i, keyboard_data_in_i,
                   mouse_clock_in_i, mouse_data_in_i}),
        .q_o     (kbd_sync)
    );

    // Reading a status register clears it
    assign clr_lo = rd_clear(rd, idx, `WER_IDX_STAT_LO);
    assign clr_hi = rd_clear(rd, idx, `WER_IDX_STAT_HI);

    // Software event is already on this clock, so it skips the synchroniser
    assign lvl_lo = {sync_lo[7], ctrl_r[`WER_CTRL_SWEV_BIT], sync_lo[5:0]};

    wer_sticky u_stat_lo
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .lvl_i   (lvl_lo),
        .clr_i   (clr_lo),
        .stat_o  (stat_lo)
    );

    wer_sticky u_stat_hi
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .lvl_i   (sync_hi),
        .clr_i   (clr_hi),
        .stat_o  (stat_hi)
    );

    // Wake enables deliberately absent from the two routed outputs
    assign mgt_any = route_any(stat_lo, stat_hi,
                               mgt_lo_r, mgt_hi_r);
    assign irq_any = route_any(stat_lo, stat_hi,
                               irq_lo_r, irq_hi_r);
    assign pwr_any = route_any(stat_lo, stat_hi,
                               en_lo_r, en_hi_r);
    assign hevt    = {5'h00, pwr_any & ~prev_pwr_r,
                      irq_any & ~prev_irq_r, mgt_any & ~prev_mgt_r};

    always @*
    begin
        rd_nxt  = 8'h00;
        hit_nxt = 1'b1;
        case (idx)
            `WER_IDX_STAT_LO: rd_nxt = stat_lo;
            `WER_IDX_STAT_HI: rd_nxt = stat_hi;
            `WER_IDX_EN_LO:   rd_nxt = en_lo_r;
            `WER_IDX_EN_HI:   rd_nxt = en_hi_r;
            `WER_IDX_CFG:     rd_nxt = cfg_r;
            `WER_IDX_CTRL:    rd_nxt = {6'h00, ctrl_r};
            `WER_IDX_HSTAT:   rd_nxt = hstat_r;
            `WER_IDX_HMASK:   rd_nxt = hmask_r;
            `WER_IDX_MGT_LO:  rd_nxt = mgt_lo_r;
            `WER_IDX_MGT_HI:  rd_nxt = mgt_hi_r;
            `WER_IDX_IRQ_LO:  rd_nxt = irq_lo_r;
            `WER_IDX_IRQ_HI:  rd_nxt = irq_hi_r;
            default:          hit_nxt = 1'b0;
        endcase
        // Banked routing space visible only in bank 2
        if (idx >= `WER_IDX_MGT_LO &&
            !in_bank2(cfg_r[`WER_CFG_BANK_LSB +: 2]))
        begin
            rd_nxt  = 8'h00;
            hit_nxt = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_r    <= `WER_RST_BYTE;
            mgt_lo_r <= `WER_RST_BYTE;
            mgt_hi_r <= `WER_RST_BYTE;
            irq_lo_r <= `WER_RST_BYTE;
            irq_hi_r <= `WER_RST_BYTE;
            en_lo_r  <= `WER_RST_BYTE;
            en_hi_r  <= `WER_RST_BYTE;
            ctrl_r   <= 2'h0;
            hmask_r  <= `WER_RST_BYTE;
        end
        else if (wr)
        begin
            case (idx)
                // Reserved bits masked here so they always read zero
                `WER_IDX_CFG:
                    cfg_r <= wb_dat_i[7:0] & `WER_CFG_MASK;
                `WER_IDX_EN_LO:  en_lo_r <= wb_dat_i[7:0];
                `WER_IDX_EN_HI:  en_hi_r <= wb_dat_i[7:0];
                `WER_IDX_CTRL:   ctrl_r <= wb_dat_i[1:0];
                `WER_IDX_HMASK:  hmask_r <= wb_dat_i[7:0];
                `WER_IDX_MGT_LO:
                    mgt_lo_r <= wb_dat_i[7:0] & `WER_LO_MASK;
                `WER_IDX_MGT_HI: mgt_hi_r <= wb_dat_i[7:0];
                `WER_IDX_IRQ_LO:
                    irq_lo_r <= wb_dat_i[7:0] & `WER_LO_MASK;
                `WER_IDX_IRQ_HI: irq_hi_r <= wb_dat_i[7:0];
                default:         cfg_r <= cfg_r;
            endcase
        end
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o   <= 1'b0;
            wb_err_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            hstat_r    <= 8'h00;
            prev_mgt_r <= 1'b0;
            prev_irq_r <= 1'b0;
            prev_pwr_r <= 1'b0;
        end
        else
        begin
            wb_ack_o   <= req & hit_nxt;
            wb_err_o   <= req & ~hit_nxt;
            wb_dat_o   <= rd ? {24'h000000, rd_nxt} : 32'h0000_0000;
            prev_mgt_r <= mgt_any;
            prev_irq_r <= irq_any;
            prev_pwr_r <= pwr_any;
            // New event beats the read-clear
            if (rd && idx == `WER_IDX_HSTAT)
                hstat_r <= hevt;
            else
                hstat_r <= hstat_r | hevt;
        end
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctlr_kbd_clock_o          <= 1'b0;
            ctlr_kbd_data_o           <= 1'b0;
            ctlr_mouse_clock_o        <= 1'b0;
            ctlr_mouse_data_o         <= 1'b0;
            system_mgmt_interrupt_n_o <= 1'b1;
            wakeup_irq_o              <= 1'b0;
            power_wake_request_n_o    <= 1'b1;
            pb_pulse_s3_en_o          <= 1'b0;
            host_irq_o                <= 1'b0;
        end
        else
        begin
            if (cfg_r[`WER_CFG_SWAP_BIT])
            begin
                ctlr_kbd_clock_o   <= kbd_sync[1];
                ctlr_kbd_data_o    <= kbd_sync[0];
                ctlr_mouse_clock_o <= kbd_sync[3];
                ctlr_mouse_data_o  <= kbd_sync[2];
            end
            else
            begin
                ctlr_kbd_clock_o   <= kbd_sync[3];
                ctlr_kbd_data_o    <= kbd_sync[2];
                ctlr_mouse_clock_o <= kbd_sync[1];
                ctlr_mouse_data_o  <= kbd_sync[0];
            end
            system_mgmt_interrupt_n_o <= ~mgt_any;
            wakeup_irq_o              <= irq_any;
            power_wake_request_n_o    <= ~pwr_any;
            pb_pulse_s3_en_o          <= cfg_r[`WER_CFG_PB_BIT];
            host_irq_o                <= |(hstat_r & hmask_r);
        end
    end
endmodule

// ---- test/wer_host_model.sv ----
// Host side model: classic Wishbone master for the routing block.
// Assumes the slave answers every request with ack or err.
`timescale 1ns/1ps
module wer_host_model
(
    input  wire         clk_i,
    input  wire  [31:0] wb_dat_i,
    input  wire         wb_ack_i,
    input  wire         wb_err_i,
    output logic        wb_cyc_o,
    output logic        wb_stb_o,
    output logic        wb_we_o,
    output logic [6:0]  wb_adr_o,
    output logic [3:0]  wb_sel_o,
    output logic [31:0] wb_dat_o
);
    initial
    begin
        wb_cyc_o = 1'h0;
        wb_stb_o = 1'h0;
        wb_we_o  = 1'h0;
        wb_adr_o = 7'h00;
        wb_sel_o = 4'h1;
        wb_dat_o = 32'h0;
    end
    // Byte register at word index i; only the bench timeout ends a wait
    task automatic xfer(input logic w, input logic [4:0] i,
        input logic [7:0] d, output logic [7:0] q, output logic e);
        begin
            @(posedge clk_i);
            wb_cyc_o <= 1'h1;
            wb_stb_o <= 1'h1;
            wb_we_o  <= w;
            wb_adr_o <= {i, 2'h0};
            wb_dat_o <= {24'h0, d};
            @(posedge clk_i);
            while (!(wb_ack_i || wb_err_i))
                @(posedge clk_i);
            q = wb_dat_i[7:0];
            e = wb_err_i;
            wb_cyc_o <= 1'h0;
            wb_stb_o <= 1'h0;
        end
    endtask
endmodule

// ---- test/wer_props.sv ----
// Checker for the routing block, bound to its top module.
// Assumes one clock; mirrors register writes at the take edge.
`timescale 1ns/1ps
module wer_props
(
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [6:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        system_mgmt_interrupt_n_o,
    input wire        wakeup_irq_o,
    input wire        power_wake_request_n_o,
    input wire        pb_pulse_s3_en_o
);
    wire        tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [4:0]  ix = wb_adr_i[6:2];
    wire        rt = ix >= 5'h13 && ix <= 5'h16;
    logic [7:0] sh [0:31];
    wire [1:0]  bk = sh[4][1:0];
    wire [7:0]  mk = ix == 5'h04 ? 8'h0f :
                     (ix == 5'h13 || ix == 5'h15) ? 8'h5f : 8'hff;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            for (int i = 0; i < 32; i++)
                sh[i] <= 8'h00;
        else if (tk && wb_we_i && wb_sel_i[0] && !(rt && bk != 2'h2))
            sh[ix] <= wb_dat_i[7:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rst;
        $rose(rst_n_i) |-> system_mgmt_interrupt_n_o &&
            power_wake_request_n_o && !wakeup_irq_o && !pb_pulse_s3_en_o;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    property p_ans;
        tk |=> wb_ack_o != wb_err_o;
    endproperty
    a_ans: assert property (p_ans) else $error("no single answer");
    property p_bank;
        tk && rt && bk != 2'h2 |=> wb_err_o && !wb_ack_o;
    endproperty
    a_bank: assert property (p_bank) else $error("bank not gated");
    property p_rdbk;
        tk && !wb_we_i && (ix == 5'h04 || rt && bk == 2'h2) |=>
            wb_ack_o && wb_dat_o == {24'h0, $past(sh[ix] & mk)};
    endproperty
    a_rdbk: assert property (p_rdbk) else $error("bad readback");
    property p_pb;
        $rose(sh[4][3]) |-> ##[0:2] pb_pulse_s3_en_o;
    endproperty
    a_pb: assert property (p_pb) else $error("pulse enable lost");
    property p_mgt;
        sh[5'h13] == 8'h00 && sh[5'h14] == 8'h00 |-> ##2
            system_mgmt_interrupt_n_o;
    endproperty
    a_mgt: assert property (p_mgt) else $error("unrouted mgmt");
    property p_irq;
        sh[5'h15] == 8'h00 && sh[5'h16] == 8'h00 |-> ##2 !wakeup_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("unrouted irq");
    property p_wake;
        sh[2] == 8'h00 && sh[3] == 8'h00 |-> ##2 power_wake_request_n_o;
    endproperty
    a_wake: assert property (p_wake) else $error("unenabled wake");
    c_err: cover property (wb_err_o);
    c_irq: cover property ($rose(wakeup_irq_o));
    c_mgt: cover property ($fell(system_mgmt_interrupt_n_o));
endmodule
bind wer_top wer_props u_props (.*);

// ---- test/wakeup_event_routing_tb.sv ----
// Self-checking bench for the wake-up event routing block.
// Assumes the host model drives the bus; events are pin levels.
`timescale 1ns/1ps
module wakeup_event_routing_tb;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [6:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        ring_indicator_one_i = 1'h0, ring_indicator_two_i = 1'h0;
    logic        keyboard_event_i = 1'h0, mouse_event_i = 1'h0;
    logic        consumer_infrared_i = 1'h0, ring_event_i = 1'h0;
    logic [7:0]  general_event_input_i = 8'h00;
    logic        keyboard_clock_in_i = 1'h0, keyboard_data_in_i = 1'h0;
    logic        mouse_clock_in_i = 1'h0, mouse_data_in_i = 1'h0;
    logic        ctlr_kbd_clock_o, ctlr_kbd_data_o, ctlr_mouse_clock_o;
    logic        ctlr_mouse_data_o, system_mgmt_interrupt_n_o, wakeup_irq_o;
    logic        power_wake_request_n_o, pb_pulse_s3_en_o, host_irq_o;
    logic [7:0]  q;
    logic        e;
    int          miscompares = 0, compares = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    wer_top uut (.*);
    wer_host_model host (.clk_i(clk_i), .wb_dat_i(wb_dat_o),
        .wb_ack_i(wb_ack_o), .wb_err_i(wb_err_o), .wb_cyc_o(wb_cyc_i),
        .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
        .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] i, input logic [7:0] d);
        host.xfer(1'h1, i, d, q, e);
    endtask
    task rd(input logic [4:0] i);
        host.xfer(1'h0, i, 8'h00, q, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task t_reset;
        rd(5'h04);
        chk({e, q}, 9'h000);
        chk({system_mgmt_interrupt_n_o, power_wake_request_n_o,
            wakeup_irq_o, pb_pulse_s3_en_o}, 4'hc);
        rd(5'h13);
        chk(e, 1'h1);
        rd(5'h1f);
        chk(e, 1'h1);
        $display("t_reset done");
    endtask
    task t_cfg;
        wr(5'h04, 8'hfe);
        rd(5'h04);
        chk({e, q}, 9'h00e);
        chk(pb_pulse_s3_en_o, 1'h1);
        keyboard_clock_in_i <= 1'h1;
        mouse_data_in_i <= 1'h1;
        // Three sync stages, agreement filter and output flop
        wt(8);
        chk({ctlr_kbd_clock_o, ctlr_kbd_data_o, ctlr_mouse_clock_o,
            ctlr_mouse_data_o}, 4'h6);
        wr(5'h04, 8'h02);
        wt(3);
        chk({ctlr_kbd_clock_o, ctlr_kbd_data_o, ctlr_mouse_clock_o,
            ctlr_mouse_data_o}, 4'h9);
        rd(5'h13);
        chk({e, pb_pulse_s3_en_o}, 2'h0);
        $display("t_cfg done");
    endtask
    task t_route;
        wr(5'h13, 8'hff);
        rd(5'h13);
        chk(q, 8'h5f);
        wr(5'h15, 8'hff);
        rd(5'h15);
        chk(q, 8'h5f);
        wr(5'h13, 8'h00);
        wr(5'h15, 8'h04);
        keyboard_event_i <= 1'h1;
        wt(10);
        chk({wakeup_irq_o, system_mgmt_interrupt_n_o,
            power_wake_request_n_o}, 3'h7);
        rd(5'h00);
        chk(q, 8'h04);
        wt(3);
        chk(wakeup_irq_o, 1'h0);
        $display("t_route done");
    endtask
    task t_gen;
        wr(5'h14, 8'h10);
        general_event_input_i <= 8'h10;
        wt(10);
        chk({system_mgmt_interrupt_n_o, power_wake_request_n_o},
            2'h1);
        rd(5'h01);
        chk(q, 8'h10);
        // Shared input four must settle low first, else the filter hides the edge
        wr(5'h08, 8'h02);
        wt(8);
        ring_event_i <= 1'h1;
        wt(10);
        chk(system_mgmt_interrupt_n_o, 1'h0);
        rd(5'h01);
        chk(q, 8'h10);
        wt(3);
        chk({system_mgmt_interrupt_n_o, host_irq_o}, 2'h2);
        $display("t_gen done");
    endtask
    task t_wake;
        wr(5'h0a, 8'h04);
        wr(5'h02, 8'h01);
        ring_indicator_one_i <= 1'h1;
        wt(10);
        chk({power_wake_request_n_o, host_irq_o, wakeup_irq_o}, 3'h2);
        rd(5'h09);
        chk(q, 8'h07);
        wt(2);
        chk(host_irq_o, 1'h0);
        rd(5'h00);
        wt(3);
        chk(power_wake_request_n_o, 1'h1);
        wr(5'h13, 8'h40);
        wr(5'h08, 8'h03);
        wt(8);
        chk(system_mgmt_interrupt_n_o, 1'h0);
        rd(5'h00);
        chk(q, 8'h40);
        $display("t_wake done");
    endtask
    task end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Whole run is under two hundred cycles; ceiling leaves ample margin
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            end_sim;
        end
    end
    initial
    begin
        wt(10);
        rst_n_i <= 1'h1;
        t_reset;
        t_cfg;
        t_route;
        t_gen;
        t_wake;
        end_sim;
    end
endmodule
